// >>> core/radio_modem_config_registers.sv
// modem configuration registers on an avalon-mm slave with derived modem settings
`timescale 1ns/1ps
`include "modem_cfg_defines.svh"

module radio_modem_config_registers
	import modem_cfg_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic [17:0] address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	input  wire modem_in_type  dp_in,
	output modem_out_type      dp_out
);

	// ==========================================================
	// state and decode
	bank_state_type st_reg;
	bank_state_type st_next;
	bank_state_type st_reset;

	logic        hit_high;
	logic        hit_low;
	logic        hit_dev;
	logic        request;
	logic        accept_write;
	logic [7:0]  read_mux;
	logic [11:0] spacing;
	logic [10:0] deviation;
	logic [4:0]  preamble;
	logic [19:0] channel_offset;
	logic [25:0] plain_word;
	logic [25:0] shift_word;

	assign hit_high = address == {`CFG_HIGH_IDX, 2'b00};
	assign hit_low  = address == {`CFG_LOW_IDX, 2'b00};
	assign hit_dev  = address == {`CFG_DEV_IDX, 2'b00};
	assign request  = read | write;
	assign accept_write = write & ~st_reg.waitrequest & byteenable[0];

	// ==========================================================
	// arithmetic helpers
	mant_exp_scale #(
		.MW (8),
		.EW (2),
		.OW (12)
	) u_spacing (
		.mantissa (st_reg.modem_config_low),
		.exponent (st_reg.modem_config_high[`SPC_EXP_MSB:`SPC_EXP_LSB]),
		.scaled   (spacing)
	);

	mant_exp_scale #(
		.MW (3),
		.EW (3),
		.OW (11)
	) u_deviation (
		.mantissa (st_reg.frequency_deviation_setting[`DEV_MANT_MSB:`DEV_MANT_LSB]),
		.exponent (st_reg.frequency_deviation_setting[`DEV_EXP_MSB:`DEV_EXP_LSB]),
		.scaled   (deviation)
	);

	preamble_decode u_preamble (
		.code  (st_reg.modem_config_high[`PREAMBLE_MSB:`PREAMBLE_LSB]),
		.bytes (preamble)
	);

	// spacing times channel, added to base, all in fref/2^18 steps
	assign channel_offset = 20'(spacing * dp_in.channel_number);
	assign plain_word = 26'(dp_in.base_frequency + 26'(channel_offset));
	// deviation is in fref/2^17 steps, so it doubles in the carrier's units
	assign shift_word = 26'({deviation, 1'b0});

	// ==========================================================
	// reset image
	always_comb begin
		st_reset = '0;
		st_reset.modem_config_high = `CFG_HIGH_RESET;
		st_reset.modem_config_low = `CFG_LOW_RESET;
		st_reset.frequency_deviation_setting = `CFG_DEV_RESET;
		st_reset.waitrequest = 1'b1;
	end

	// ==========================================================
	// read multiplexer
	always_comb begin
		read_mux = 8'h00;
		if (hit_high) begin
			read_mux = st_reg.modem_config_high & `CFG_HIGH_MASK;
		end else if (hit_low) begin
			read_mux = st_reg.modem_config_low;
		end else if (hit_dev) begin
			read_mux = st_reg.frequency_deviation_setting & `CFG_DEV_MASK;
		end
	end

	// ==========================================================
	// next state
	always_comb begin
		st_next = st_reg;

		// one wait cycle, then the answer for one cycle
		st_next.waitrequest = ~(request & st_reg.waitrequest);
		if (request && st_reg.waitrequest) begin
			st_next.readdata = read ? read_mux : 8'h00;
		end

		if (accept_write && hit_high) begin
			st_next.modem_config_high = writedata[7:0] & `CFG_HIGH_MASK;
		end
		if (accept_write && hit_low) begin
			st_next.modem_config_low = writedata[7:0];
		end
		if (accept_write && hit_dev) begin
			st_next.frequency_deviation_setting = writedata[7:0] & `CFG_DEV_MASK;
		end

		// settings for the datapath
		st_next.dp.error_correction_enable =
			st_reg.modem_config_high[`ERROR_CORRECTION_ENABLE_BIT];
		st_next.dp.preamble_bytes = preamble;
		st_next.dp.channel_spacing = spacing;
		st_next.dp.frequency_deviation = deviation;
		st_next.dp.carrier_word = plain_word;
		st_next.dp.rx_expected_deviation = 11'h000;
		st_next.dp.msk_phase_eighths = 4'h0;
		st_next.dp.msk_phase_up = 1'b0;

		if (dp_in.tx_active && !dp_in.msk_mode) begin
			// fsk transmit: one goes up, zero goes down
			st_next.dp.carrier_word = dp_in.tx_symbol ?
				26'(plain_word + shift_word) :
				26'(plain_word - shift_word);
		end else if (dp_in.tx_active) begin
			st_next.dp.msk_phase_eighths = 4'({1'b0,
				st_reg.frequency_deviation_setting[`DEV_MANT_MSB:`DEV_MANT_LSB]} + 4'h1);
			st_next.dp.msk_phase_up = ~dp_in.tx_symbol;
		end else if (!dp_in.msk_mode) begin
			st_next.dp.rx_expected_deviation = deviation;
		end
		// msk receive leaves the expected deviation at zero
	end

	// ==========================================================
	// state register
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st_reg <= st_reset;
		end else begin
			st_reg <= st_next;
		end
	end

	assign readdata    = {24'h000000, st_reg.readdata};
	assign waitrequest = st_reg.waitrequest;
	assign dp_out      = st_reg.dp;

	// ==========================================================
	// assertions
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	a_fec_follows_bit: assert property (
		accept_write && hit_high |=> ##1
		dp_out.error_correction_enable == $past(writedata[7], 2))
		else $error("error correction enable does not follow written bit");

	a_preamble_longest: assert property (
		st_reg.modem_config_high[6:4] == 3'h7 |=> dp_out.preamble_bytes == 5'h18)
		else $error("preamble code 7 must give 24 bytes");

	a_preamble_shortest: assert property (
		st_reg.modem_config_high[6:4] == 3'h0 |=> dp_out.preamble_bytes == 5'h02)
		else $error("preamble code 0 must give 2 bytes");

	a_reset_values: assert property (@(posedge clock) disable iff (1'b0)
		sys_rst |=> st_reg.modem_config_high == 8'h22 &&
		st_reg.modem_config_low == 8'hf8 && st_reg.waitrequest)
		else $error("reset values wrong");

	a_spacing_formula: assert property (
		!sys_rst |=> dp_out.channel_spacing ==
		12'((12'h100 + 12'($past(st_reg.modem_config_low))) <<
		$past(st_reg.modem_config_high[1:0])))
		else $error("channel spacing formula mismatch");

	a_deviation_formula: assert property (
		!sys_rst |=> dp_out.frequency_deviation ==
		11'((11'h008 + 11'($past(st_reg.frequency_deviation_setting[2:0]))) <<
		$past(st_reg.frequency_deviation_setting[6:4])))
		else $error("deviation formula mismatch");

	a_fsk_shift_dir: assert property (
		dp_in.tx_active && !dp_in.msk_mode |=> dp_out.carrier_word ==
		($past(dp_in.tx_symbol) ? 26'($past(plain_word) + $past(shift_word)) :
		26'($past(plain_word) - $past(shift_word))))
		else $error("fsk carrier shift wrong");

	a_msk_fraction: assert property (
		dp_in.tx_active && dp_in.msk_mode |=>
		dp_out.msk_phase_eighths != 4'h0 && dp_out.msk_phase_eighths <= 4'h8 &&
		dp_out.msk_phase_up == !$past(dp_in.tx_symbol))
		else $error("msk phase fraction or direction wrong");

	a_msk_rx_ignore: assert property (
		!dp_in.tx_active && dp_in.msk_mode |=> dp_out.rx_expected_deviation == 11'h000)
		else $error("msk receive used the deviation setting");

	a_unused_zero: assert property (
		read && !waitrequest |-> readdata[31:8] == 24'h000000 &&
		(!hit_high || readdata[3:2] == 2'b00) &&
		(!hit_dev || (readdata[7] == 1'b0 && readdata[3] == 1'b0)))
		else $error("unused bits read nonzero");

	// preamble table, one code per property
	a_preamble_three: assert property (
		!sys_rst && st_reg.modem_config_high[6:4] == 3'h1 |=> dp_out.preamble_bytes == 5'h03)
		else $error("preamble code 1 must give 3 bytes");

	a_preamble_four: assert property (
		!sys_rst && st_reg.modem_config_high[6:4] == 3'h2 |=> dp_out.preamble_bytes == 5'h04)
		else $error("preamble code 2 must give 4 bytes");

	a_preamble_six: assert property (
		!sys_rst && st_reg.modem_config_high[6:4] == 3'h3 |=> dp_out.preamble_bytes == 5'h06)
		else $error("preamble code 3 must give 6 bytes");

	a_preamble_eight: assert property (
		!sys_rst && st_reg.modem_config_high[6:4] == 3'h4 |=> dp_out.preamble_bytes == 5'h08)
		else $error("preamble code 4 must give 8 bytes");

	a_preamble_twelve: assert property (
		!sys_rst && st_reg.modem_config_high[6:4] == 3'h5 |=> dp_out.preamble_bytes == 5'h0c)
		else $error("preamble code 5 must give 12 bytes");

	a_preamble_sixteen: assert property (
		!sys_rst && st_reg.modem_config_high[6:4] == 3'h6 |=> dp_out.preamble_bytes == 5'h10)
		else $error("preamble code 6 must give 16 bytes");

	a_fec_off_clear: assert property (
		!sys_rst && !st_reg.modem_config_high[7] |=> !dp_out.error_correction_enable)
		else $error("error correction on while its bit is clear");

	a_fec_on_set: assert property (
		!sys_rst && st_reg.modem_config_high[7] |=> dp_out.error_correction_enable)
		else $error("error correction off while its bit is set");

	a_low_write_lands: assert property (
		accept_write && hit_low |=> st_reg.modem_config_low == $past(writedata[7:0]))
		else $error("mantissa write did not land");

	a_high_write_masked: assert property (
		accept_write && hit_high |=> st_reg.modem_config_high == ($past(writedata[7:0]) & 8'hf3))
		else $error("high register write not masked");

	a_dev_write_masked: assert property (
		accept_write && hit_dev |=> st_reg.frequency_deviation_setting == ($past(writedata[7:0]) & 8'h77))
		else $error("deviation register write not masked");

	a_carrier_idle: assert property (
		!sys_rst && !dp_in.tx_active |=> dp_out.carrier_word == 26'(
		$past(dp_in.base_frequency) +
		26'((12'h100 + 12'($past(st_reg.modem_config_low))) <<
		$past(st_reg.modem_config_high[1:0])) * 26'($past(dp_in.channel_number))))
		else $error("idle carrier word off the formula");

	a_rx_fsk_deviation: assert property (
		!sys_rst && !dp_in.tx_active && !dp_in.msk_mode |=>
		dp_out.rx_expected_deviation ==
		11'((11'h008 + 11'($past(st_reg.frequency_deviation_setting[2:0]))) <<
		$past(st_reg.frequency_deviation_setting[6:4])))
		else $error("receive deviation off the formula");

	a_msk_eighths_value: assert property (
		dp_in.tx_active && dp_in.msk_mode |=>
		dp_out.msk_phase_eighths ==
		4'(4'h1 + 4'($past(st_reg.frequency_deviation_setting[2:0]))))
		else $error("msk phase fraction does not follow the mantissa");

	a_fsk_carrier_value: assert property (
		!sys_rst && dp_in.tx_active && !dp_in.msk_mode |=> dp_out.carrier_word == 26'(
		$past(dp_in.base_frequency) +
		26'((12'h100 + 12'($past(st_reg.modem_config_low))) <<
		$past(st_reg.modem_config_high[1:0])) * 26'($past(dp_in.channel_number)) +
		26'((11'h008 + 11'($past(st_reg.frequency_deviation_setting[2:0]))) <<
		$past(st_reg.frequency_deviation_setting[6:4])) * 26'h0000002 *
		($past(dp_in.tx_symbol) ? 26'h0000001 : 26'h3ffffff)))
		else $error("fsk carrier word off the formula");

	c_write_accepted: cover property (accept_write && hit_dev);
	c_read_answer: cover property (read && !waitrequest && hit_high);
	c_fsk_one: cover property (dp_in.tx_active && !dp_in.msk_mode && dp_in.tx_symbol);
	c_msk_tx: cover property (dp_in.tx_active && dp_in.msk_mode);
	c_msk_rx: cover property (!dp_in.tx_active && dp_in.msk_mode);

endmodule : radio_modem_config_registers

// >>> include/modem_cfg_defines.svh
// offsets, field positions and reset values of the modem configuration registers
`ifndef MODEM_CFG_DEFINES_SVH
`define MODEM_CFG_DEFINES_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define CFG_HIGH_IDX      16'hdf0f
`define CFG_LOW_IDX       16'hdf10
`define CFG_DEV_IDX       16'hdf11

// ==========================================================
// field positions
`define ERROR_CORRECTION_ENABLE_BIT        7
`define PREAMBLE_MSB      6
`define PREAMBLE_LSB      4
`define SPC_EXP_MSB       1
`define SPC_EXP_LSB       0
`define DEV_EXP_MSB       6
`define DEV_EXP_LSB       4
`define DEV_MANT_MSB      2
`define DEV_MANT_LSB      0

// ==========================================================
// writable bit masks and reset values
`define CFG_HIGH_MASK     8'hf3
`define CFG_DEV_MASK      8'h77
`define CFG_HIGH_RESET    8'h22
`define CFG_LOW_RESET     8'hf8
`define CFG_DEV_RESET     8'h47

`endif

// >>> include/modem_cfg_pkg.sv
// types shared by the modem configuration register bank
package modem_cfg_pkg;

	// ==========================================================
	// datapath inputs from the modem
	typedef struct packed {
		logic        tx_active;
		logic        msk_mode;
		logic        tx_symbol;
		logic [7:0]  channel_number;
		logic [25:0] base_frequency;
	} modem_in_type;

	// ==========================================================
	// settings handed to the modem datapath
	typedef struct packed {
		logic        error_correction_enable;
		logic [4:0]  preamble_bytes;
		logic [11:0] channel_spacing;
		logic [10:0] frequency_deviation;
		logic [25:0] carrier_word;
		logic [10:0] rx_expected_deviation;
		logic [3:0]  msk_phase_eighths;
		logic        msk_phase_up;
	} modem_out_type;

	// ==========================================================
	// whole state of the register bank
	typedef struct packed {
		logic [7:0]    modem_config_high;
		logic [7:0]    modem_config_low;
		logic [7:0]    frequency_deviation_setting;
		logic          waitrequest;
		logic [7:0]    readdata;
		modem_out_type dp;
	} bank_state_type;

endpackage : modem_cfg_pkg

// >>> core/mant_exp_scale.sv
// mantissa with implied leading one, shifted left by an exponent
`timescale 1ns/1ps
module mant_exp_scale #(
	parameter int MW = 8,
	parameter int EW = 2,
	parameter int OW = 12
) (
	input  wire logic [MW-1:0] mantissa,
	input  wire logic [EW-1:0] exponent,
	output logic      [OW-1:0] scaled
);
	logic [OW-1:0] base_value;

	assign base_value = OW'({1'b1, mantissa});
	assign scaled     = base_value << exponent;
endmodule : mant_exp_scale

// >>> core/preamble_decode.sv
// preamble length code to minimum number of preamble bytes
`timescale 1ns/1ps
module preamble_decode (
	input  wire logic [2:0] code,
	output logic      [4:0] bytes
);
	always_comb begin
		case (code)
			3'h0:    bytes = 5'h02;
			3'h1:    bytes = 5'h03;
			3'h2:    bytes = 5'h04;
			3'h3:    bytes = 5'h06;
			3'h4:    bytes = 5'h08;
			3'h5:    bytes = 5'h0c;
			3'h6:    bytes = 5'h10;
			3'h7:    bytes = 5'h18;
			default: bytes = 5'h02;
		endcase
	end
endmodule : preamble_decode

// >>> test/tb_radio_modem_config_registers.sv
// self-checking testbench of the modem configuration register bank
`timescale 1ns/1ps
module tb_radio_modem_config_registers;
	import modem_cfg_pkg::*;

	localparam logic [17:0] a_high = 18'h37c3c;
	localparam logic [17:0] a_low  = 18'h37c40;
	localparam logic [17:0] a_dev  = 18'h37c44;
	localparam logic [25:0] base   = 26'h0100000;

	logic          clock;
	logic          sys_rst;
	logic [17:0]   address;
	logic          read;
	logic          write;
	logic [31:0]   writedata;
	logic [3:0]    byteenable;
	logic [31:0]   readdata;
	logic          waitrequest;
	modem_in_type  dp_in;
	modem_out_type dp_out;
	int            errors;
	int            total_checks;

	radio_modem_config_registers radio_modem_config_registers_i (
		.clock(clock), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .dp_in(dp_in), .dp_out(dp_out));

	// ==========================================
	// checking and bus tasks
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch register at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_reg

	task automatic chk_dp(input logic [25:0] got, input logic [25:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch datapath at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_dp

	task automatic bus(input logic rd, input logic [17:0] adr, input logic [7:0] wd,
			input logic [3:0] be, output logic [31:0] rdata);
		@(posedge clock);
		address <= adr;
		read <= rd;
		write <= !rd;
		writedata <= {24'h000000, wd};
		byteenable <= be;
		do begin
			@(posedge clock);
		end while (waitrequest !== 1'b0);
		rdata = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus

	task automatic wr(input logic [17:0] adr, input logic [7:0] wd);
		logic [31:0] d;
		bus(1'b0, adr, wd, 4'hf, d);
	endtask : wr

	task automatic rd_chk(input logic [17:0] adr, input logic [31:0] exp);
		logic [31:0] d;
		bus(1'b1, adr, 8'h00, 4'hf, d);
		chk_reg(d, exp);
	endtask : rd_chk

	task automatic drive_dp(input logic tx, input logic msk, input logic sym);
		@(posedge clock);
		dp_in <= '{tx_active: tx, msk_mode: msk, tx_symbol: sym,
			channel_number: 8'h05, base_frequency: base};
		repeat (3) @(posedge clock);
		@(negedge clock);
	endtask : drive_dp

	// ==========================================
	// scenarios
	task automatic t_reset;
		rd_chk(a_high, 32'h00000022);
		rd_chk(a_low, 32'h000000f8);
		rd_chk(a_dev, 32'h00000047);
		drive_dp(1'b0, 1'b0, 1'b0);
		chk_dp(dp_out.preamble_bytes, 26'h4);
		chk_dp(dp_out.error_correction_enable, 26'h0);
		chk_dp(dp_out.channel_spacing, 26'h7e0);
		chk_dp(dp_out.frequency_deviation, 26'h0f0);
	endtask : t_reset

	task automatic t_reserved;
		logic [31:0] d;
		wr(a_high, 8'hff);
		rd_chk(a_high, 32'h000000f3);
		wr(a_dev, 8'hff);
		rd_chk(a_dev, 32'h00000077);
		wr(18'h37c48, 8'h55);
		rd_chk(18'h37c48, 32'h00000000);
		bus(1'b0, a_low, 8'h12, 4'he, d);
		rd_chk(a_low, 32'h000000f8);
	endtask : t_reserved

	task automatic t_preamble;
		logic [4:0] tbl [8] = '{5'd2, 5'd3, 5'd4, 5'd6, 5'd8, 5'd12, 5'd16, 5'd24};
		logic [2:0] c;
		// coding turned on for the odd preamble codes only
		for (int i = 0; i < 8; i++) begin
			c = i[2:0];
			wr(a_high, {c[0], c, 4'h2});
			drive_dp(1'b0, 1'b0, 1'b0);
			chk_dp(dp_out.preamble_bytes, {21'h0, tbl[i]});
			chk_dp(dp_out.error_correction_enable, {25'h0, c[0]});
		end
	endtask : t_preamble

	task automatic t_spacing;
		logic [11:0] sp;
		wr(a_low, 8'h00);
		for (int e = 0; e < 4; e++) begin
			wr(a_high, {6'h00, e[1:0]});
			drive_dp(1'b0, 1'b0, 1'b0);
			sp = 12'h100 << e;
			chk_dp(dp_out.channel_spacing, {14'h0, sp});
			chk_dp(dp_out.carrier_word, base + sp * 26'd5);
		end
		wr(a_low, 8'h0a);
		drive_dp(1'b0, 1'b0, 1'b0);
		chk_dp(dp_out.channel_spacing, 26'h850);
	endtask : t_spacing

	task automatic t_deviation;
		logic [25:0] ctr;
		ctr = base + 26'h850 * 26'd5;
		// deviation matched to the incoming signal for fsk receive, zero for msk receive
		wr(a_dev, 8'h23);
		drive_dp(1'b1, 1'b0, 1'b0);
		chk_dp(dp_out.frequency_deviation, 26'h02c);
		chk_dp(dp_out.carrier_word, ctr - 26'd88);
		drive_dp(1'b1, 1'b0, 1'b1);
		chk_dp(dp_out.carrier_word, ctr + 26'd88);
		drive_dp(1'b0, 1'b0, 1'b0);
		chk_dp(dp_out.rx_expected_deviation, 26'h02c);
		drive_dp(1'b0, 1'b1, 1'b0);
		chk_dp(dp_out.rx_expected_deviation, 26'h0);
		drive_dp(1'b1, 1'b1, 1'b0);
		chk_dp(dp_out.msk_phase_eighths, 26'h4);
		chk_dp(dp_out.msk_phase_up, 26'h1);
		wr(a_dev, 8'h07);
		drive_dp(1'b1, 1'b1, 1'b1);
		chk_dp(dp_out.msk_phase_eighths, 26'h8);
		chk_dp(dp_out.msk_phase_up, 26'h0);
	endtask : t_deviation

	// ==========================================
	// verdict, clock, watchdog and main sequence
	task automatic close_out;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	initial begin
		repeat (5000) @(posedge clock);
		errors++;
		close_out();
	end

	initial begin
		errors = 0;
		total_checks = 0;
		sys_rst = 1'b1;
		address = 18'h00000;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h00000000;
		byteenable = 4'h0;
		dp_in = '0;
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		t_reset();
		t_reserved();
		t_preamble();
		t_spacing();
		t_deviation();
		close_out();
	end
endmodule : tb_radio_modem_config_registers
